/* File: rtl/wdcm_top.sv */
// Windowed watchdog with clock monitor, register port and interrupt.
`timescale 1ns/1ps
`include "wdcm_params.svh"
module wdcm_top
  import wdcm_pkg::*;
#(
  parameter int CM_GAP_CYC = `WDCM_CM_GAP_CYC
)
(
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  input  wire logic       WD_OPTION_EN,
  input  wire logic       HIGH_SPEED_MODE,
  input  wire logic       INSTR_CYCLE,
  input  wire logic       LS_CLK_IN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            IRQ,
  input  wire logic       WD_PIN_I,
  output logic            WD_PIN_O,
  output logic            WD_PIN_OE
);

  // ****************************************************************
  // Declarations and functions
  // ****************************************************************
  logic [1:0]  sync1_r;
  logic [1:0]  sync2_r;
  logic        ls_prev_r;
  logic        opt_taken_r;
  logic        wd_en_r;
  logic        configured_r;
  logic [1:0]  win_r;
  logic        cm_en_r;
  logic [3:0]  stat_r;
  logic [3:0]  stat_nxt;
  logic [3:0]  mask_r;
  logic [4:0]  hold_r;
  logic [13:0] gap_r;
  logic        clk_bad_r;
  logic [15:0] idle_cnt_r;
  wdcm_state_t state_r;
  wdcm_state_t state_nxt;
  logic        idle_tick;
  logic        svc_wr;
  logic        key_ok;
  logic        full_ok;
  logic        valid_svc;
  logic        err_early;
  logic        err_late;
  logic        err_mism;
  logic        err_clk;
  logic        any_err;
  logic        restart;
  logic        upper_hit;
  logic        lower_hit;
  logic        pin_high;
  logic        ls_level;
  wdcm_cnt_t   upper_limit;

  // Window select to upper limit in idle ticks.
  function automatic wdcm_cnt_t win_to_limit(input logic [1:0] sel);
    wdcm_cnt_t lim;
    case (sel)
      2'h0:    lim = `WDCM_UPPER_8K;
      2'h1:    lim = `WDCM_UPPER_16K;
      2'h2:    lim = `WDCM_UPPER_32K;
      default: lim = `WDCM_UPPER_64K;
    endcase
    return lim;
  endfunction

  // Register address match, used by both the write and read decoders.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ****************************************************************
  // Input synchronisers, idle ticks and option capture
  // ****************************************************************

  // The slow clock and the pin level come from outside the core domain.
  assign ls_level = sync2_r[0];
  assign pin_high = sync2_r[1];

  // Two flops per asynchronous input; only the second stage is ever read.
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_N)
        begin
          sync1_r[i] <= 1'b1;
          sync2_r[i] <= 1'b1;
        end
        else if (CE)
        begin
          sync1_r[i] <= (i == 0) ? LS_CLK_IN : WD_PIN_I;
          sync2_r[i] <= sync1_r[i];
        end
      end
    end
  endgenerate

  // Rising-edge detector on the synchronised slow clock.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      ls_prev_r <= 1'b1;
    else if (CE)
      ls_prev_r <= ls_level;
  end

  // Window time is in idle ticks; their source follows the speed mode.
  assign idle_tick = HIGH_SPEED_MODE ? INSTR_CYCLE : (ls_level && !ls_prev_r);

  // Free-running idle tick counter, readable by software for alignment.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      idle_cnt_r <= 16'h0000;
    else if (CE && idle_tick)
      idle_cnt_r <= idle_cnt_r + 16'h0001;
  end

  // The option level is caught once after reset release, never under reset.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      opt_taken_r <= 1'b0;
      wd_en_r     <= 1'b0;
    end
    else if (CE && !opt_taken_r)
    begin
      opt_taken_r <= 1'b1;
      wd_en_r     <= WD_OPTION_EN;
    end
  end

  // ****************************************************************
  // Service decode and window limit checkers
  // ****************************************************************

  // Services while the pin is active are ignored, as is anything without the option.
  assign svc_wr  = WR && hit(ADDR, `WDCM_ADDR_SVC) && wd_en_r
                   && (state_r == WDCM_ARMED);
  assign key_ok  = WDATA[`WDCM_KEY_MSB:`WDCM_KEY_LSB] == `WDCM_KEY_VAL;
  assign full_ok = key_ok && (WDATA[`WDCM_WIN_MSB:`WDCM_WIN_LSB] == win_r)
                   && (WDATA[`WDCM_CM_BIT] == cm_en_r);

  // The first service may land inside the lower limit; later ones may not.
  assign valid_svc = svc_wr && (configured_r ? (full_ok && lower_hit) : key_ok);
  assign err_mism  = svc_wr && (configured_r ? !full_ok : !key_ok);
  assign err_early = svc_wr && configured_r && full_ok && !lower_hit;
  assign err_late  = wd_en_r && (state_r == WDCM_ARMED) && upper_hit && !svc_wr;
  assign err_clk   = wd_en_r && (state_r == WDCM_ARMED) && cm_en_r && clk_bad_r;
  assign any_err   = err_mism || err_early || err_late || err_clk;

  // Both counts restart on a valid service, when the pin goes high again, or while the option is off.
  assign restart = valid_svc || !wd_en_r
                   || ((state_r == WDCM_RELEASE) && pin_high);

  // Window select and monitor enable are fixed by the first keyed write.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      configured_r <= 1'b0;
      win_r        <= `WDCM_WIN_RST;
      cm_en_r      <= `WDCM_CM_RST;
    end
    else if (CE && svc_wr && !configured_r && key_ok)
    begin
      configured_r <= 1'b1;
      win_r        <= WDATA[`WDCM_WIN_MSB:`WDCM_WIN_LSB];
      cm_en_r      <= WDATA[`WDCM_CM_BIT];
    end
  end

  // Upper limit in idle ticks from the fixed window select.
  assign upper_limit = win_to_limit(win_r);

  // Upper limit: longest allowed interval between services.
  wdcm_limit_checker upper_limit_checker
  (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .tick    (idle_tick),
    .restart (restart),
    .limit   (upper_limit),
    .reached (upper_hit)
  );

  // Lower limit: fixed, catches a loop that services too often.
  wdcm_limit_checker lower_limit_checker
  (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .tick    (idle_tick),
    .restart (restart),
    .limit   (`WDCM_LOWER_TICKS),
    .reached (lower_hit)
  );

  // ****************************************************************
  // Clock monitor
  // ****************************************************************

  // Core cycles since the last instruction cycle; too long a gap is a slow clock.
  // A stopped core clock cannot be seen here; the instruction strobe stands in for it.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      gap_r     <= 14'h0000;
      clk_bad_r <= 1'b0;
    end
    else if (CE)
    begin
      if (INSTR_CYCLE)
      begin
        gap_r     <= 14'h0000;
        clk_bad_r <= 1'b0;
      end
      else if (32'(gap_r) >= (CM_GAP_CYC - 1))
        clk_bad_r <= 1'b1;
      else
        gap_r <= gap_r + 14'h0001;
    end
  end

  // ****************************************************************
  // Output pin sequencer
  // ****************************************************************

  // Drive low, wait for the pin to fall, hold, then wait for the pull-up.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      WDCM_ARMED:
        if (any_err)
          state_nxt = WDCM_DRIVE;
      WDCM_DRIVE:
        if (!pin_high)
          state_nxt = WDCM_HOLD;
      WDCM_HOLD:
        if (hold_r == (`WDCM_HOLD_CYC - 5'h01))
          state_nxt = WDCM_RELEASE;
      WDCM_RELEASE:
        if (pin_high)
          state_nxt = WDCM_ARMED;
      default:
        state_nxt = WDCM_ARMED;
    endcase
    if (!wd_en_r)
      state_nxt = WDCM_ARMED;
  end

  // Sequencer state.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      state_r <= WDCM_ARMED;
    else if (CE)
      state_r <= state_nxt;
  end

  // Hold count; a persisting clock error keeps restarting it, so the pin stays low.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      hold_r <= 5'h00;
    else if (CE)
    begin
      if ((state_r != WDCM_HOLD) || (cm_en_r && clk_bad_r))
        hold_r <= 5'h00;
      else
        hold_r <= hold_r + 5'h01;
    end
  end

  // Open-drain pin: the level driven is always low, only the enable moves.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      WD_PIN_O  <= 1'b0;
      WD_PIN_OE <= 1'b0;
    end
    else if (CE)
    begin
      WD_PIN_O  <= 1'b0;
      WD_PIN_OE <= (state_nxt == WDCM_DRIVE) || (state_nxt == WDCM_HOLD);
    end
  end

  // ****************************************************************
  // Status, mask, interrupt and read port
  // ****************************************************************

  // A new event in the clearing cycle survives: set wins over write-one-to-clear.
  always_comb
  begin
    stat_nxt = stat_r;
    if (WR && hit(ADDR, `WDCM_ADDR_STAT))
      stat_nxt = stat_r & ~WDATA[3:0];
    stat_nxt[`WDCM_ST_EARLY] = stat_nxt[`WDCM_ST_EARLY] | err_early;
    stat_nxt[`WDCM_ST_LATE]  = stat_nxt[`WDCM_ST_LATE] | err_late;
    stat_nxt[`WDCM_ST_MISM]  = stat_nxt[`WDCM_ST_MISM] | err_mism;
    stat_nxt[`WDCM_ST_CLK]   = stat_nxt[`WDCM_ST_CLK] | err_clk;
  end

  // Status and mask registers.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
    end
    else if (CE)
    begin
      stat_r <= stat_nxt;
      if (WR && hit(ADDR, `WDCM_ADDR_MASK))
        mask_r <= WDATA[3:0];
    end
  end

  // Level interrupt, registered, so it follows status by one cycle.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      IRQ <= 1'b0;
    else if (CE)
      IRQ <= |(stat_r & mask_r);
  end

  // Read data stand only in the cycle after the strobe; the key always reads zero.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      RDATA <= 8'h00;
    else if (CE)
    begin
      RDATA <= 8'h00;
      if (RD)
      begin
        if (hit(ADDR, `WDCM_ADDR_SVC))
          RDATA <= {win_r, 5'h00, cm_en_r};
        else if (hit(ADDR, `WDCM_ADDR_STAT))
          RDATA <= {4'h0, stat_r};
        else if (hit(ADDR, `WDCM_ADDR_MASK))
          RDATA <= {4'h0, mask_r};
        else if (hit(ADDR, `WDCM_ADDR_STATE))
          RDATA <= {2'h0, pin_high, clk_bad_r, state_r, configured_r, wd_en_r};
        else if (hit(ADDR, `WDCM_ADDR_IDLE))
          RDATA <= idle_cnt_r[15:8];
      end
    end
  end

endmodule

/* File: rtl/wdcm_params.svh */
// Constant macros for the windowed watchdog and clock monitor.
`ifndef WDCM_PARAMS_SVH
`define WDCM_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define WDCM_ADDR_SVC    8'h00
`define WDCM_ADDR_STAT   8'h01
`define WDCM_ADDR_MASK   8'h02
`define WDCM_ADDR_STATE  8'h03
`define WDCM_ADDR_IDLE   8'h04

// ****************************************************************
// Service word fields and reset values
// ****************************************************************
`define WDCM_WIN_MSB     7
`define WDCM_WIN_LSB     6
`define WDCM_KEY_MSB     5
`define WDCM_KEY_LSB     1
`define WDCM_CM_BIT      0
`define WDCM_KEY_VAL     5'h0C
`define WDCM_WIN_RST     2'h3
`define WDCM_CM_RST      1'h1

// ****************************************************************
// Status bit positions
// ****************************************************************
`define WDCM_ST_EARLY    0
`define WDCM_ST_LATE     1
`define WDCM_ST_MISM     2
`define WDCM_ST_CLK      3

// ****************************************************************
// Window limits in idle ticks and timing counts
// ****************************************************************
`define WDCM_LOWER_TICKS 17'h00800
`define WDCM_UPPER_8K    17'h02000
`define WDCM_UPPER_16K   17'h04000
`define WDCM_UPPER_32K   17'h08000
`define WDCM_UPPER_64K   17'h10000
`define WDCM_HOLD_CYC    5'h10
`define WDCM_CLK_PER_NS  25
`define WDCM_CM_GAP_NS   200000
`define WDCM_CM_GAP_CYC  (`WDCM_CM_GAP_NS / `WDCM_CLK_PER_NS)

`endif

/* File: rtl/wdcm_pkg.sv */
// Types shared by the watchdog and clock monitor modules.
package wdcm_pkg;

  // Error sequencing of the watchdog output pin.
  typedef enum logic [1:0]
  {
    WDCM_ARMED   = 2'b00,
    WDCM_DRIVE   = 2'b01,
    WDCM_HOLD    = 2'b10,
    WDCM_RELEASE = 2'b11
  } wdcm_state_t;

  typedef logic [16:0] wdcm_cnt_t;

endpackage

/* File: rtl/wdcm_limit_checker.sv */
// One window limit checker counting idle ticks up to a limit.
`timescale 1ns/1ps
module wdcm_limit_checker
  import wdcm_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      ce,
  input  wire logic      tick,
  input  wire logic      restart,
  input  wire wdcm_cnt_t limit,
  output logic           reached
);

  wdcm_cnt_t cnt_r;

  // Count ticks and saturate at the limit, so a late check never wraps back to zero.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (ce)
    begin
      if (restart)
        cnt_r <= '0;
      else if (tick && (cnt_r < limit))
        cnt_r <= cnt_r + 17'h00001;
    end
  end

  // Registered flag; it drops on the cycle after a restart.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reached <= 1'b0;
    else if (ce)
      reached <= !restart && (cnt_r >= limit);
  end

endmodule

/* File: test/wdcm_top_chk.sv */
// Port-level checker for the windowed watchdog and clock monitor.
`timescale 1ns/1ps
`include "wdcm_params.svh"
module wdcm_top_chk
#(
  parameter int CM_GAP_CYC = 32
)
(
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       CE,
  input wire logic       WD_OPTION_EN,
  input wire logic       HIGH_SPEED_MODE,
  input wire logic       INSTR_CYCLE,
  input wire logic       LS_CLK_IN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       IRQ,
  input wire logic       WD_PIN_I,
  input wire logic       WD_PIN_O,
  input wire logic       WD_PIN_OE
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [2:0] idle_r;

  // Cycles since the pin was released; saturating so the block counts as armed at 7.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N || WD_PIN_OE)
      idle_r <= 3'h0;
    else if (idle_r != 3'h7)
      idle_r <= idle_r + 3'h1;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_hold;
    WD_PIN_OE [*8] ##1 WD_PIN_OE [*8];
  endsequence
  property p_rdata_idle;
    !(RD && CE) |=> RDATA == 8'h00;
  endproperty
  property p_key_hidden;
    (RD && CE && ADDR == `WDCM_ADDR_SVC) |=> RDATA[5:1] == 5'h00;
  endproperty
  property p_unmapped;
    (RD && CE && ADDR > `WDCM_ADDR_IDLE) |=> RDATA == 8'h00;
  endproperty
  property p_pin_level;
    WD_PIN_O == 1'b0;
  endproperty
  property p_hold_min;
    $rose(WD_PIN_OE) |-> s_hold;
  endproperty
  property p_hold_max;
    $rose(WD_PIN_OE) |-> ##[17:1000] !WD_PIN_OE;
  endproperty
  property p_release_after_low;
    $fell(WD_PIN_OE) |-> $past(WD_PIN_I, 16) == 1'b0;
  endproperty
  property p_option_off;
    (!WD_OPTION_EN && $past(!WD_OPTION_EN, 4)) |-> !WD_PIN_OE;
  endproperty
  property p_bad_key;
    (WR && CE && ADDR == `WDCM_ADDR_SVC && WDATA[5:1] != `WDCM_KEY_VAL && WD_OPTION_EN
      && idle_r == 3'h7) |=> WD_PIN_OE;
  endproperty

  a_rdata_idle:        assert property (p_rdata_idle) else $error("read data not idle");
  a_key_hidden:        assert property (p_key_hidden) else $error("key readable");
  a_unmapped:          assert property (p_unmapped) else $error("unmapped read");
  a_pin_level:         assert property (p_pin_level) else $error("pin drives high");
  a_hold_min:          assert property (p_hold_min) else $error("pin released early");
  a_hold_max:          assert property (p_hold_max) else $error("pin held too long");
  a_release_after_low: assert property (p_release_after_low) else $error("release too soon");
  a_option_off:        assert property (p_option_off) else $error("inactive watchdog drives");
  a_bad_key:           assert property (p_bad_key) else $error("bad key not flagged");
endmodule

/* File: test/wdcm_top_tb.sv */
// Self-checking testbench for the windowed watchdog and clock monitor.
`timescale 1ns/1ps
`include "wdcm_params.svh"
module wdcm_top_tb;
  import wdcm_pkg::*;
  localparam int CM_GAP = 32;
  localparam logic [7:0] SVC_OK = {2'b00, `WDCM_KEY_VAL, 1'b1};
  localparam logic [7:0] SVC_BADWIN = {2'b01, `WDCM_KEY_VAL, 1'b1};
  localparam logic [7:0] SVC_BADKEY = {2'b00, 5'h0D, 1'b1};
  logic       CORE_CLK = 1'b0;
  logic       RST_N = 1'b0;
  logic       CE = 1'b1;
  logic       WD_OPTION_EN = 1'b1;
  logic       HIGH_SPEED_MODE = 1'b1;
  logic       INSTR_CYCLE = 1'b0;
  logic       LS_CLK_IN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic [7:0] RDATA;
  logic       IRQ;
  logic       WD_PIN_O;
  logic       WD_PIN_OE;
  wire        WD_PIN_I;
  logic       ic_run = 1'b1;
  int         n_fail = 0;
  int         n_compared = 0;

  // The pin has a pull-up, so it reads high whenever the block is not pulling it.
  assign WD_PIN_I = WD_PIN_OE ? WD_PIN_O : 1'b1;

  // Core clock at 40 MHz.
  always #12.5 CORE_CLK = ~CORE_CLK;

  // Slow 32 kHz clock, unrelated in phase to the core clock.
  always #15625 LS_CLK_IN = ~LS_CLK_IN;

  // Instruction pulse every second cycle, so one idle tick is two core cycles.
  always @(posedge CORE_CLK)
  begin
    INSTR_CYCLE <= ic_run & ~INSTR_CYCLE;
  end

  wdcm_top #(.CM_GAP_CYC(CM_GAP)) i_wdcm_top (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .WD_OPTION_EN(WD_OPTION_EN),
    .HIGH_SPEED_MODE(HIGH_SPEED_MODE), .INSTR_CYCLE(INSTR_CYCLE), .LS_CLK_IN(LS_CLK_IN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
    .WD_PIN_I(WD_PIN_I), .WD_PIN_O(WD_PIN_O), .WD_PIN_OE(WD_PIN_OE));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask

  // Waits, bounded, for a whole pin sequence: pull low, hold, release, re-arm.
  task automatic pin_cycle(input int lim);
    for (int i = 0; i < lim && WD_PIN_OE !== 1'b1; i++) @(negedge CORE_CLK);
    chk({7'h0, WD_PIN_OE}, 8'h01);
    for (int i = 0; i < 2000 && WD_PIN_OE !== 1'b0; i++) @(negedge CORE_CLK);
    chk({7'h0, WD_PIN_OE}, 8'h00);
    cyc(6);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short; the tests take about 30000 core cycles.
  initial
  begin
    #(25 * 40000);
    n_fail++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [7:0] d;
    repeat (10) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    cyc(2);
    rd(`WDCM_ADDR_SVC, d);
    chk(d, 8'hC1);
    rd(`WDCM_ADDR_STATE, d);
    chk(d, 8'h21);
    rd(8'h10, d);
    chk(d, 8'h00);
    // First keyed write inside the lower limit is accepted and fixes the window.
    wr(`WDCM_ADDR_SVC, SVC_OK);
    cyc(4);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h00);
    rd(`WDCM_ADDR_SVC, d);
    chk(d, 8'h01);
    // A second correct service straight away is too early.
    wr(`WDCM_ADDR_SVC, SVC_OK);
    cyc(1);
    chk({7'h0, WD_PIN_OE}, 8'h01);
    pin_cycle(10);
    chk({7'h0, WD_PIN_OE}, 8'h00);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h01);
    wr(`WDCM_ADDR_STAT, 8'hFF);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h00);
    // Past 2048 ticks a matching service is valid.
    cyc(4200);
    wr(`WDCM_ADDR_SVC, SVC_OK);
    cyc(4);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h00);
    // Right timing but another window is a mismatch; it raises the interrupt once its mask bit is set.
    cyc(4200);
    wr(`WDCM_ADDR_SVC, SVC_BADWIN);
    cyc(2);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h04);
    chk({7'h0, IRQ}, 8'h00);
    wr(`WDCM_ADDR_MASK, 8'h04);
    cyc(2);
    chk({7'h0, IRQ}, 8'h01);
    wr(`WDCM_ADDR_STAT, 8'h04);
    cyc(2);
    chk({7'h0, IRQ}, 8'h00);
    pin_cycle(10);
    // No service: the 8k upper limit expires after 16384 core cycles.
    cyc(16000);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h00);
    pin_cycle(1500);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h02);
    wr(`WDCM_ADDR_STAT, 8'hFF);
    // In low-speed mode only slow clock edges count, so this service is early.
    HIGH_SPEED_MODE <= 1'b0;
    cyc(4200);
    wr(`WDCM_ADDR_SVC, SVC_OK);
    cyc(2);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h01);
    pin_cycle(10);
    @(posedge CORE_CLK);
    HIGH_SPEED_MODE <= 1'b1;
    wr(`WDCM_ADDR_STAT, 8'hFF);
    // A stopped instruction clock is a clock error while the monitor is enabled.
    ic_run <= 1'b0;
    cyc(CM_GAP + 20);
    chk({7'h0, WD_PIN_OE}, 8'h01);
    ic_run <= 1'b1;
    pin_cycle(10);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h08);
    // A wrong key is a mismatch; a low clock enable freezes the sequencer in the drive state meanwhile, so the pin stays pulled.
    wr(`WDCM_ADDR_STAT, 8'hFF);
    wr(`WDCM_ADDR_SVC, SVC_BADKEY);
    CE <= 1'b0;
    cyc(40);
    chk({7'h0, WD_PIN_OE}, 8'h01);
    @(posedge CORE_CLK);
    CE <= 1'b1;
    pin_cycle(10);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h04);
    // With the option off, a bad key does nothing.
    @(posedge CORE_CLK);
    RST_N <= 1'b0;
    WD_OPTION_EN <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    cyc(2);
    rd(`WDCM_ADDR_SVC, d);
    chk(d, 8'hC1);
    wr(`WDCM_ADDR_SVC, 8'h00);
    cyc(4);
    chk({7'h0, WD_PIN_OE}, 8'h00);
    rd(`WDCM_ADDR_STAT, d);
    chk(d, 8'h00);
    final_report();
  end
endmodule

bind wdcm_top wdcm_top_chk #(.CM_GAP_CYC(CM_GAP_CYC)) i_wdcm_top_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .WD_OPTION_EN(WD_OPTION_EN),
  .HIGH_SPEED_MODE(HIGH_SPEED_MODE), .INSTR_CYCLE(INSTR_CYCLE), .LS_CLK_IN(LS_CLK_IN),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
  .WD_PIN_I(WD_PIN_I), .WD_PIN_O(WD_PIN_O), .WD_PIN_OE(WD_PIN_OE));
